/* File: logic/phgc_core_if.sv */
// signals passed between the register top and its two helper modules
`timescale 1ns/100ps
interface phgc_core_if;
    logic [15:0] page_word;     // captured partner page
    logic        page_new;      // one-cycle pulse, page just loaded
    logic [15:0] ctrl_word;     // gigabit control register
    logic        forced_gig;    // autoneg off and 1000 forced
    logic [2:0]  tx_mode;
    logic [3:0]  pair_test;
    logic        ms_manual;
    logic        ms_master;
    logic        port_pref;
    logic        adv_fd;
    logic        adv_hd;

    modport cap (output page_word, output page_new);
    modport cfg (input ctrl_word, input forced_gig, output tx_mode, output pair_test,
                 output ms_manual, output ms_master, output port_pref,
                 output adv_fd, output adv_hd);
    modport top (input page_word, input page_new, output ctrl_word, output forced_gig,
                 input tx_mode, input pair_test, input ms_manual, input ms_master,
                 input port_pref, input adv_fd, input adv_hd);
endinterface : phgc_core_if

/* File: logic/phgc_ms_cfg.sv */
// decode of the control word into transmitter and negotiation controls
`timescale 1ns/100ps
module phgc_ms_cfg (
    input  wire logic clk_sys,
    input  wire logic rst_sync_n,
    phgc_core_if.cfg  core
);
    logic [2:0] mode_reg,  mode_next;
    logic [3:0] pair_reg,  pair_next;
    logic       man_reg,   man_next;
    logic       mst_reg,   mst_next;
    logic       pref_reg,  pref_next;
    logic       fd_reg,    fd_next;
    logic       hd_reg,    hd_next;

    // reserved codes fall back to normal so no undefined pattern goes out
    function automatic logic [2:0] legal_mode(input logic [2:0] code);
        legal_mode = (code > 3'(phgc_pkg::TXM_DISTORT)) ? 3'(phgc_pkg::TXM_NORMAL) : code;
    endfunction : legal_mode

    always_comb begin
        mode_next = legal_mode(core.ctrl_word[phgc_pkg::GC_MODE_HI:phgc_pkg::GC_MODE_LO]);
        // test patterns only once speed is forced, on every pair
        pair_next = (core.forced_gig && mode_next != 3'(phgc_pkg::TXM_NORMAL)) ? 4'hf : 4'h0;
        man_next  = core.ctrl_word[phgc_pkg::GC_MANUAL_BIT];
        // forced role is meaningless without manual mode
        mst_next  = man_next & core.ctrl_word[phgc_pkg::GC_MASTER_BIT];
        // preference only counts while manual mode is off
        pref_next = ~man_next & core.ctrl_word[phgc_pkg::GC_PORT_BIT];
        fd_next   = core.ctrl_word[phgc_pkg::GC_FD_BIT];
        hd_next   = core.ctrl_word[phgc_pkg::GC_HD_BIT];
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_reg <= phgc_pkg::GC_RESET[phgc_pkg::GC_MODE_HI:phgc_pkg::GC_MODE_LO];
            pair_reg <= 4'h0;
            man_reg  <= phgc_pkg::GC_RESET[phgc_pkg::GC_MANUAL_BIT];
            mst_reg  <= 1'b0;
            pref_reg <= 1'b0;
            fd_reg   <= phgc_pkg::GC_RESET[phgc_pkg::GC_FD_BIT];
            hd_reg   <= phgc_pkg::GC_RESET[phgc_pkg::GC_HD_BIT];
        end else begin
            mode_reg <= mode_next;
            pair_reg <= pair_next;
            man_reg  <= man_next;
            mst_reg  <= mst_next;
            pref_reg <= pref_next;
            fd_reg   <= fd_next;
            hd_reg   <= hd_next;
        end
    end

    assign core.tx_mode   = mode_reg;
    assign core.pair_test = pair_reg;
    assign core.ms_manual = man_reg;
    assign core.ms_master = mst_reg;
    assign core.port_pref = pref_reg;
    assign core.adv_fd    = fd_reg;
    assign core.adv_hd    = hd_reg;
endmodule : phgc_ms_cfg

/* File: logic/phgc_page_capture.sv */
// atomic capture of each next page received from the link partner
`timescale 1ns/100ps
module phgc_page_capture (
    input  wire logic        clk_sys,
    input  wire logic        rst_sync_n,
    input  wire logic        an_page_valid,
    input  wire logic [15:0] an_page_word,
    phgc_core_if.cap         core
);
    logic [15:0] page_reg;
    logic [15:0] page_next;
    logic        new_reg;
    logic        new_next;

    // whole word loads in one edge, never a mix of pages
    always_comb begin
        page_next = page_reg;
        new_next  = 1'b0;
        if (an_page_valid) begin
            page_next = an_page_word;
            new_next  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            page_reg <= phgc_pkg::PNP_RESET;
            new_reg  <= 1'b0;
        end else begin
            page_reg <= page_next;
            new_reg  <= new_next;
        end
    end

    assign core.page_word = page_reg;
    assign core.page_new  = new_reg;
endmodule : phgc_page_capture

/* File: logic/phgc_pkg.sv */
// shared constants for the gigabit control and partner next-page registers
package phgc_pkg;
    // register offsets on the management port
    localparam logic [4:0]  OFS_PARTNER_NP = 5'h08;
    localparam logic [4:0]  OFS_GIG_CTRL   = 5'h09;
    localparam int          ADDR_W         = 5;
    localparam int          DATA_W         = 16;

    // partner next-page field positions
    localparam int          PNP_NEXT_BIT   = 15;
    localparam int          PNP_ACK_BIT    = 14;
    localparam int          PNP_MSG_BIT    = 13;
    localparam int          PNP_ACK2_BIT   = 12;
    localparam int          PNP_TOG_BIT    = 11;
    localparam int          PNP_CODE_HI    = 10;
    localparam int          PNP_CODE_LO    = 0;
    localparam logic [15:0] PNP_RESET      = 16'h0000;

    // gigabit control field positions
    localparam int          GC_MODE_HI     = 15;
    localparam int          GC_MODE_LO     = 13;
    localparam int          GC_MANUAL_BIT  = 12;
    localparam int          GC_MASTER_BIT  = 11;
    localparam int          GC_PORT_BIT    = 10;
    localparam int          GC_FD_BIT      = 9;
    localparam int          GC_HD_BIT      = 8;
    localparam logic [15:0] GC_RESET       = 16'h0200;
    localparam logic [15:0] GC_WR_MASK     = 16'hff00;

    localparam int          NUM_PAIRS      = 4;

    // transmitter mode encodings
    typedef enum logic [2:0] {
        TXM_NORMAL   = 3'h0,
        TXM_WAVEFORM = 3'h1,
        TXM_JIT_MST  = 3'h2,
        TXM_JIT_SLV  = 3'h3,
        TXM_DISTORT  = 3'h4
    } phgc_txmode_t;
endpackage : phgc_pkg

/* File: logic/phgc_regs.sv */
// partner next-page and gigabit control registers of one phy port
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - bit 15 of partner page says more pages follow (1) or last (0).
// - bit 14 read-only shows partner acknowledge of our link word.
// - bit 13 message or unformatted page; bits 10:0 the received code.
// - bit 12 read-only shows partner second acknowledge.
// - bit 11 read-only shows partner toggle bit.
// - control bits 15:13 pick transmitter mode, normal after reset.
// - selected test pattern goes out on all four pairs only while forced_gig is set, no partner needed.
// - bit 12 enables manual master/slave, reset zero.
// - bit 11 forces master or slave, ignored unless manual enabled.
// - bit 10 port preference, valid only without manual mode, reset zero.
// - bit 9 advertises gigabit full duplex, reset one.
// - bit 8 advertises gigabit half duplex, reset zero.
// - each new partner page sets a latched page-received flag.
module phgc_regs (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        an_page_valid,
    input  wire logic [15:0] an_page_word,
    input  wire logic        forced_gig,
    input  wire logic        pg_rcvd_clr,
    output logic             pg_rcvd_flag,
    output logic      [2:0]  tx_mode,
    output logic      [3:0]  tx_pair_test,
    output logic             ms_manual_en,
    output logic             ms_force_master,
    output logic             ms_port_pref,
    output logic             adv_gig_fd,
    output logic             adv_gig_hd
);
    ////////////////////////////////////////////////////////////////////////////
    logic        rst_meta_reg;
    logic        rst_sync_n;
    logic [15:0] ctrl_reg,  ctrl_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        flag_reg,  flag_next;

    phgc_core_if core ();

    // reset release through two stages, assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    phgc_page_capture u_capture (
        .clk_sys       (clk_sys),
        .rst_sync_n    (rst_sync_n),
        .an_page_valid (an_page_valid),
        .an_page_word  (an_page_word),
        .core          (core.cap)
    );

    phgc_ms_cfg u_cfg (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_n),
        .core       (core.cfg)
    );

    assign core.ctrl_word  = ctrl_reg;
    assign core.forced_gig = forced_gig;

    ////////////////////////////////////////////////////////////////////////////
    // register writes, read mux and page-received flag
    function automatic logic is_hit(input logic [4:0] a, input logic [4:0] ofs);
        is_hit = (a == ofs);
    endfunction : is_hit

    always_comb begin
        ctrl_next  = ctrl_reg;
        rdata_next = 16'h0000;
        flag_next  = flag_reg;
        // low byte masked off on write, so it always reads zero
        if (reg_wr && is_hit(reg_addr, phgc_pkg::OFS_GIG_CTRL)) begin
            ctrl_next = reg_wdata & phgc_pkg::GC_WR_MASK;
        end
        // partner page is read-only; writes to it are dropped
        if (reg_rd) begin
            if (is_hit(reg_addr, phgc_pkg::OFS_PARTNER_NP)) begin
                rdata_next = core.page_word;
            end else if (is_hit(reg_addr, phgc_pkg::OFS_GIG_CTRL)) begin
                rdata_next = ctrl_reg;
            end
        end
        // clear first, then set, so an arriving page is never lost
        if (pg_rcvd_clr) begin
            flag_next = 1'b0;
        end
        if (core.page_new) begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_reg  <= phgc_pkg::GC_RESET;
            rdata_reg <= 16'h0000;
            flag_reg  <= 1'b0;
        end else begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
            flag_reg  <= flag_next;
        end
    end

    // outputs all come straight from flip-flops
    assign reg_rdata       = rdata_reg;
    assign pg_rcvd_flag    = flag_reg;
    assign tx_mode         = core.tx_mode;
    assign tx_pair_test    = core.pair_test;
    assign ms_manual_en    = core.ms_manual;
    assign ms_force_master = core.ms_master;
    assign ms_port_pref    = core.port_pref;
    assign adv_gig_fd      = core.adv_fd;
    assign adv_gig_hd      = core.adv_hd;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_wr_ctrl;
        reg_wr && reg_addr == phgc_pkg::OFS_GIG_CTRL;
    endsequence

    chk_page_atomic: assert property (
        an_page_valid ##1 !an_page_valid ##1 (reg_rd && reg_addr == phgc_pkg::OFS_PARTNER_NP)
            |=> reg_rdata == $past(an_page_word, 3))
        else $error("partner page read does not match received word");

    chk_page_fields: assert property (
        an_page_valid ##1 (!an_page_valid && reg_rd && reg_addr == phgc_pkg::OFS_PARTNER_NP)
            |=> reg_rdata[15:11] == $past(an_page_word[15:11], 2))
        else $error("partner page flag bits wrong");

    chk_page_ro: assert property (
        reg_wr && reg_addr == phgc_pkg::OFS_PARTNER_NP && !an_page_valid
            |=> $stable(core.page_word))
        else $error("write changed partner page");

    chk_flag_set: assert property (
        an_page_valid |=> ##1 pg_rcvd_flag)
        else $error("page received flag not set");

    chk_flag_hold: assert property (
        pg_rcvd_flag && !pg_rcvd_clr |=> pg_rcvd_flag)
        else $error("page received flag dropped without clear");

    chk_ctrl_low_zero: assert property (
        reg_rd && reg_addr == phgc_pkg::OFS_GIG_CTRL |=> reg_rdata[7:0] == 8'h00)
        else $error("reserved control bits not zero");

    chk_ctrl_write: assert property (
        s_wr_ctrl ##1 (reg_rd && reg_addr == phgc_pkg::OFS_GIG_CTRL)
            |=> reg_rdata[15:8] == $past(reg_wdata[15:8], 2))
        else $error("control write not read back");

    chk_test_pairs: assert property (
        (s_wr_ctrl and (reg_wdata[15:13] == 3'h1 && forced_gig))
            ##1 (forced_gig && !reg_wr)
            |=> tx_pair_test == 4'hf && tx_mode == 3'h1)
        else $error("test mode not driven on all pairs");

    chk_test_gated: assert property (
        !$past(forced_gig) |-> tx_pair_test == 4'h0)
        else $error("test pattern without forced gigabit");

    chk_master_ignored: assert property (
        !ms_manual_en |-> !ms_force_master)
        else $error("master force active without manual mode");

    chk_pref_valid: assert property (
        ms_manual_en |-> !ms_port_pref)
        else $error("port preference active in manual mode");

    chk_adv_follow: assert property (
        s_wr_ctrl |=> ##1 adv_gig_fd == $past(reg_wdata[9], 2)
            && adv_gig_hd == $past(reg_wdata[8], 2))
        else $error("advertise bits do not follow control");

    chk_manual_follow: assert property (
        s_wr_ctrl |=> ##1 ms_manual_en == $past(reg_wdata[12], 2))
        else $error("manual enable does not follow control");

    chk_rdata_one: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");

    ////////////////////////////////////////////////////////////////////////////
    // address decodes shared by the checks below
    logic rd_page_hit;
    logic rd_ctrl_hit;
    assign rd_page_hit = reg_rd && is_hit(reg_addr, phgc_pkg::OFS_PARTNER_NP);
    assign rd_ctrl_hit = reg_rd && is_hit(reg_addr, phgc_pkg::OFS_GIG_CTRL);

    chk_page_next: assert property (
        rd_page_hit |=> reg_rdata[15] == $past(core.page_word[15]))
        else $error("next page bit read wrong");

    chk_page_ack: assert property (
        rd_page_hit |=> reg_rdata[14] == $past(core.page_word[14]))
        else $error("acknowledge bit read wrong");

    chk_page_code: assert property (
        rd_page_hit |=> reg_rdata[13] == $past(core.page_word[13])
            && reg_rdata[10:0] == $past(core.page_word[10:0]))
        else $error("message page or code field read wrong");

    chk_page_ack2: assert property (
        rd_page_hit |=> reg_rdata[12] == $past(core.page_word[12]))
        else $error("second acknowledge bit read wrong");

    chk_page_toggle: assert property (
        rd_page_hit |=> reg_rdata[11] == $past(core.page_word[11]))
        else $error("toggle bit read wrong");

    chk_page_load: assert property (
        an_page_valid |=> core.page_word == $past(an_page_word))
        else $error("received page not loaded whole");

    chk_page_hold: assert property (
        !an_page_valid |=> $stable(core.page_word))
        else $error("partner page changed without a new page");

    ////////////////////////////////////////////////////////////////////////////
    // flag: a page in the same cycle as a clear must survive
    chk_flag_clear: assert property (
        pg_rcvd_clr && !core.page_new |=> !pg_rcvd_flag)
        else $error("page received flag not cleared");

    chk_flag_win: assert property (
        core.page_new |=> pg_rcvd_flag)
        else $error("new page lost against clear");

    chk_flag_rise: assert property (
        $rose(pg_rcvd_flag) |-> $past(core.page_new))
        else $error("page received flag set without a page");

    ////////////////////////////////////////////////////////////////////////////
    // control register and the outputs decoded from it
    chk_ctrl_read: assert property (
        rd_ctrl_hit |=> reg_rdata == $past(ctrl_reg))
        else $error("control read data wrong");

    chk_ctrl_hold: assert property (
        !(reg_wr && reg_addr == phgc_pkg::OFS_GIG_CTRL) |=> $stable(ctrl_reg))
        else $error("control register changed without a write");

    chk_ctrl_mask: assert property (
        s_wr_ctrl |=> ctrl_reg[7:0] == 8'h00)
        else $error("reserved control bits stored");

    chk_mode_range: assert property (
        tx_mode <= 3'(phgc_pkg::TXM_DISTORT))
        else $error("transmitter mode outside defined codes");

    chk_mode_follow: assert property (
        s_wr_ctrl ##0 reg_wdata[15:13] <= 3'h4
            |=> ##1 tx_mode == $past(reg_wdata[15:13], 2))
        else $error("transmitter mode does not follow control");

    chk_master_follow: assert property (
        s_wr_ctrl |=> ##1 ms_force_master
            == ($past(reg_wdata[11], 2) && $past(reg_wdata[12], 2)))
        else $error("forced role does not follow control");

    chk_pref_follow: assert property (
        s_wr_ctrl |=> ##1 ms_port_pref
            == ($past(reg_wdata[10], 2) && !$past(reg_wdata[12], 2)))
        else $error("port preference does not follow control");

    chk_pairs_idle: assert property (
        tx_mode == 3'(phgc_pkg::TXM_NORMAL) |-> tx_pair_test == 4'h0)
        else $error("test pattern in normal mode");

    chk_unmapped_zero: assert property (
        reg_rd && !rd_page_hit && !rd_ctrl_hit |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");

    cov_page_read: cover property (
        an_page_valid ##[1:8] reg_rd && reg_addr == phgc_pkg::OFS_PARTNER_NP);
    cov_test_mode: cover property (tx_pair_test == 4'hf);
    cov_manual_master: cover property (ms_manual_en && ms_force_master);
    cov_set_clear: cover property (core.page_new && pg_rcvd_clr);
    cov_ctrl_readback: cover property (s_wr_ctrl ##1 rd_ctrl_hit);
endmodule : phgc_regs

/* File: tb/phgc_lp_model.sv */
// link partner page source driving the negotiation page port
`timescale 1ns/100ps
module phgc_lp_model (
    input  wire logic        clk_sys,
    output logic             an_page_valid,
    output logic      [15:0] an_page_word
);
    initial begin
        an_page_valid = 1'b0;
        an_page_word  = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one or two whole pages back to back; the idle word is inverted so that
    // a capture outside the valid pulse shows up as a wrong page
    task automatic send(input logic [15:0] w0, input logic [15:0] w1, input bit two);
        @(posedge clk_sys);
        an_page_valid <= 1'b1;
        an_page_word  <= w0;
        if (two) begin
            @(posedge clk_sys);
            an_page_word <= w1;
        end
        @(posedge clk_sys);
        an_page_valid <= 1'b0;
        an_page_word  <= two ? ~w1 : ~w0;
    endtask : send
endmodule : phgc_lp_model

/* File: tb/phgc_regs_tb.sv */
// self-checking bench for the partner page and gigabit control registers
`timescale 1ns/100ps
module phgc_regs_tb;
    logic        clk_sys;
    logic        rst_n;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        an_page_valid;
    logic [15:0] an_page_word;
    logic        forced_gig;
    logic        pg_rcvd_clr;
    logic        pg_rcvd_flag;
    logic [2:0]  tx_mode;
    logic [3:0]  tx_pair_test;
    logic        ms_manual_en;
    logic        ms_force_master;
    logic        ms_port_pref;
    logic        adv_gig_fd;
    logic        adv_gig_hd;
    int          miscompares;
    int          check_count;
    int          ctrl_m;
    int          page_m;
    logic [15:0] w;

    phgc_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .an_page_valid(an_page_valid), .an_page_word(an_page_word),
        .forced_gig(forced_gig), .pg_rcvd_clr(pg_rcvd_clr), .pg_rcvd_flag(pg_rcvd_flag),
        .tx_mode(tx_mode), .tx_pair_test(tx_pair_test), .ms_manual_en(ms_manual_en),
        .ms_force_master(ms_force_master), .ms_port_pref(ms_port_pref),
        .adv_gig_fd(adv_gig_fd), .adv_gig_hd(adv_gig_hd));

    phgc_lp_model lp (.clk_sys(clk_sys), .an_page_valid(an_page_valid),
        .an_page_word(an_page_word));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and a watchdog so a hang still reaches the verdict
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        miscompares++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compares and verdict
    task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg
    task automatic chk_out(input string n, input logic [3:0] e, input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk_out
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    // bus cycles; only the control offset keeps written bits, low byte dropped
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        if (a == 5'h09) ctrl_m = d & 16'hff00;
    endtask : wr
    task automatic rd(input logic [4:0] a, input int e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk_reg($sformatf("reg %h", a), 16'(e), reg_rdata);
    endtask : rd
    // derived controls expected from the modelled control word
    task automatic check_outs();
        logic [15:0] c;
        logic        t;
        c = 16'(ctrl_m);
        t = (c[15:13] inside {[3'h1:3'h4]}) && forced_gig;
        chk_out("tx_mode", (c[15:13] > 3'h4) ? 4'h0 : {1'b0, c[15:13]}, {1'b0, tx_mode});
        chk_out("pair_test", t ? 4'hf : 4'h0, tx_pair_test);
        chk_out("manual", {3'h0, c[12]}, {3'h0, ms_manual_en});
        chk_out("master", {3'h0, c[11] & c[12]}, {3'h0, ms_force_master});
        chk_out("port", {3'h0, c[10] & ~c[12]}, {3'h0, ms_port_pref});
        chk_out("adv_fd", {3'h0, c[9]}, {3'h0, adv_gig_fd});
        chk_out("adv_hd", {3'h0, c[8]}, {3'h0, adv_gig_hd});
    endtask : check_outs

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_n = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        forced_gig = 1'b0;
        pg_rcvd_clr = 1'b0;
        ctrl_m = 'h0200;
        page_m = 0;
        void'($urandom(95));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        check_outs();
        rd(5'h08, page_m);
        rd(5'h09, ctrl_m);
        // normal mode until gigabit is forced, then every defined test code
        for (int i = 0; i < 16; i++) begin
            if (i == 8) forced_gig <= 1'b1;
            wr(5'h09, {(i < 8) ? 3'h0 : 3'(i % 5), 5'($urandom), 8'($urandom)});
            @(posedge clk_sys);
            #1;
            check_outs();
            rd(5'h09, ctrl_m);
        end
        // page register is read-only, unmapped space reads zero
        wr(5'h08, 16'($urandom));
        rd(5'h08, page_m);
        wr(5'h1f, 16'hffff);
        rd(5'h1f, 0);
        rd(5'h09, ctrl_m);
        // partner pages, single and back to back, with flag set and clear
        for (int i = 0; i < 8; i++) begin
            w = 16'($urandom);
            lp.send(w, ~w, i[0]);
            page_m = i[0] ? ~w : w;
            repeat (2) @(posedge clk_sys);
            #1;
            chk_out("flag", 4'h1, {3'h0, pg_rcvd_flag});
            rd(5'h08, page_m);
            w = 16'($urandom);
            fork
                lp.send(w, w, 1'b0);
                begin
                    // clear lands on the same edge as the new page pulse
                    repeat (2) @(posedge clk_sys);
                    pg_rcvd_clr <= 1'b1;
                    @(posedge clk_sys);
                    pg_rcvd_clr <= 1'b0;
                end
            join
            page_m = w;
            repeat (2) @(posedge clk_sys);
            #1;
            chk_out("flag", 4'h1, {3'h0, pg_rcvd_flag});
            rd(5'h08, page_m);
            // read racing the page, one or two edges behind its valid pulse
            w = 16'($urandom);
            page_m = w;
            fork
                lp.send(w, w, 1'b0);
                begin
                    repeat (i[1] ? 2 : 1) @(posedge clk_sys);
                    rd(5'h08, page_m);
                end
            join
            @(posedge clk_sys);
            pg_rcvd_clr <= 1'b1;
            @(posedge clk_sys);
            pg_rcvd_clr <= 1'b0;
            @(posedge clk_sys);
            #1;
            chk_out("flag", 4'h0, {3'h0, pg_rcvd_flag});
        end
        finish_test();
    end
endmodule : phgc_regs_tb
